// *** verilog/rmdem_pkg.sv ***
package rmdem_pkg;
    // adapter count and widths
    localparam int NUM_ADAPTERS = 4;
    localparam int COUNT_WIDTH = 4;
    localparam int TIMER_WIDTH = 8;
    // register offsets (word index on the register port)
    localparam logic [3:0] OFF_CONTROL = 4'h0;
    localparam logic [3:0] OFF_DIAG = 4'h1;
    localparam logic [3:0] OFF_IRQ_REQ = 4'h2;
    localparam logic [3:0] OFF_BUS_REQ = 4'h3;
    localparam logic [3:0] OFF_LEVEL_ONE = 4'h4;
    localparam logic [3:0] OFF_LEVEL_TWO = 4'h5;
    localparam logic [3:0] OFF_MAINT = 4'h9;
    localparam logic [3:0] OFF_COMPLETION = 4'ha;
    localparam logic [3:0] OFF_IRQ_STATUS = 4'hb;
    localparam logic [3:0] OFF_IRQ_MASK = 4'hc;
    localparam logic [3:0] OFF_IDENT = 4'hd;
    // diagnostic register fields
    localparam int DIAG_COUNT_LSB = 0;
    localparam int DIAG_ODD_MODE = 4;
    localparam int DIAG_WRAP = 5;
    localparam int DIAG_START = 6;
    localparam int DIAG_FORCE_PAR = 7;
    localparam int DIAG_FORCE_TIMER = 8;
    localparam int DIAG_FORCE_TD = 9;
    localparam int DIAG_FORCE_CW = 10;
    localparam int DIAG_WRITE_DIR = 11;
    // level-two / maintenance error codes
    localparam logic [2:0] ERR_INTERNAL = 3'h1;
    localparam logic [2:0] ERR_TYPE1 = 3'h2;
    localparam logic [2:0] ERR_TYPE2 = 3'h4;
    // interrupt status bits
    localparam int IRQ_LEVEL_ONE = 0;
    localparam int IRQ_LEVEL_FOUR = 1;
    localparam int IRQ_MAINT = 2;
    localparam int IRQ_DIRECT = 3;
    localparam int IRQ_BITS = 4;
    // strobe timer limit: 100 ns at 200 MHz
    localparam int STROBE_TIMEOUT_NS = 100;
    localparam int CLK_MHZ = 200;
    localparam int STROBE_TIMEOUT_CYC = STROBE_TIMEOUT_NS * CLK_MHZ / 1000;
    // reset values
    localparam logic [31:0] RESET_WORD = 32'h0000_0000;
    typedef enum logic [1:0] {
        RMDEM_IDLE = 2'b00,
        RMDEM_XFER = 2'b01,
        RMDEM_DONE = 2'b10
    } rmdem_state_t;
endpackage

// *** verilog/rmdem_scan_wheel.sv ***
`timescale 1ns/1ps
`default_nettype none
module rmdem_scan_wheel #(
    parameter int N = 4
) (
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic [N-1:0] requests,
    input wire logic advance,
    output logic grantValid,
    output logic [$clog2(N)-1:0] grantIdx
);
    initial begin
        if (N < 2) $error("scan wheel needs at least two positions");
    end
    typedef struct packed {
        logic [$clog2(N)-1:0] pointer;
    } rmdem_wheel_t;
    rmdem_wheel_t state, next_state;
    logic found;
    logic [$clog2(N)-1:0] pick;
    // fixed rotation starting just after the last serviced position
    always_comb begin
        logic [$clog2(N)-1:0] idx;
        idx = '0;
        found = 1'b0;
        pick = '0;
        next_state = state;
        for (int i = 0; i < N; i++) begin
            idx = state.pointer + i[$clog2(N)-1:0];
            if (!found && requests[idx]) begin
                found = 1'b1;
                pick = idx;
            end
        end
        if (advance && found) begin
            next_state.pointer = pick + 1'b1;
        end
    end
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end
    assign grantValid = found;
    assign grantIdx = pick;
endmodule
`default_nettype wire

// *** verilog/rmdem_strobe_check.sv ***
`timescale 1ns/1ps
`default_nettype none
module rmdem_strobe_check #(
    parameter int TIMER_WIDTH = 8,
    parameter int LIMIT = 20
) (
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic active,
    input wire logic oddMode,
    input wire logic firstBeat,
    input wire logic strobeSeen,
    input wire logic upperStrobe,
    input wire logic lowerStrobe,
    output logic strobeError,
    output logic timeoutError
);
    initial begin
        if (LIMIT < 1 || LIMIT >= (1 << TIMER_WIDTH))
            $error("strobe timer limit out of range");
    end
    typedef struct packed {
        logic [TIMER_WIDTH-1:0] count;
    } rmdem_timer_t;
    rmdem_timer_t state, next_state;
    always_comb begin
        next_state = state;
        if (!active || strobeSeen) begin
            next_state.count = '0;
        end else if (state.count != LIMIT[TIMER_WIDTH-1:0]) begin
            next_state.count = state.count + 1'b1;
        end
    end
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end
    // odd start must open with lower lane only; even start with upper
    assign strobeError = active && strobeSeen && (!(upperStrobe || lowerStrobe)
        || (firstBeat && oddMode && upperStrobe)
        || (firstBeat && !oddMode && !upperStrobe));
    assign timeoutError = active && !strobeSeen
        && state.count == LIMIT[TIMER_WIDTH-1:0];
endmodule
`default_nettype wire

// *** verilog/ring_mux_dma_error_manager.sv ***
// Notes on behaviour
// - parity or timer error ends DMA early, level-four irq, level-two log
// - diagnostic register forces parity or timer error at a chosen byte count
// - wrap mode makes upper/lower strobes and final transfer from mode, count
// - strobe combination disagreeing with data mode counts as a DMA error
// - strobe timer flags a missing data strobe as a timeout error
// - transmit-path parity error logs level one and raises level-one interrupt
// - level-one error records the adapter number being served
// - adapter bus timeout on read leaves both data buffers untouched
// - errored write leaves central unit memory untouched
// - routing bit set logs every level-two error type in maintenance log, interrupts
// - direct interrupt when routing, interrupt-request and start bits all set
// - completion query clears maintenance register, reports interrupt kind
// - bus requests served in fixed rotating order visible by identifier
// - control-word build parity error changes control word, names adapter
// - odd-start swaps bytes on writes to central memory, even-start passes straight
`timescale 1ns/1ps
`default_nettype none
module ring_mux_dma_error_manager #(
    parameter int NUM_ADAPTERS = rmdem_pkg::NUM_ADAPTERS,
    parameter int COUNT_WIDTH = rmdem_pkg::COUNT_WIDTH
) (
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic [3:0] regAddr,
    input wire logic [31:0] regWrData,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [31:0] regRdData,
    input wire logic ringStrobe,
    input wire logic ringUpper,
    input wire logic ringLower,
    input wire logic ringParityErr,
    input wire logic ringTimeout,
    input wire logic [15:0] ringData,
    output logic [15:0] centralData,
    output logic centralWrite,
    output logic finalTransfer,
    output logic upperLowerUp,
    output logic upperLowerLo,
    output logic controlWordChanged,
    output logic irq
);
    localparam int AW = $clog2(NUM_ADAPTERS);
    initial begin
        if (NUM_ADAPTERS != 4 || COUNT_WIDTH != rmdem_pkg::COUNT_WIDTH)
            $error("only four adapters and package count width supported");
    end
    ////////////////////////////////////////////////////////////////////////
    typedef struct packed {
        rmdem_pkg::rmdem_state_t phase;
        logic [3:0] routing;
        logic [11:0] diag;
        logic [3:0] irqReq;
        logic [3:0] busReq;
        logic [7:0] levelOne;
        logic [11:0] levelTwo;
        logic [3:0] maint;
        logic [1:0] kind;
        logic [3:0] status;
        logic [3:0] mask;
        logic [AW-1:0] serving;
        logic [COUNT_WIDTH-1:0] beat;
        logic [15:0] dataBuf;
        logic [15:0] extBuf;
        logic [15:0] centralData;
        logic centralWrite;
        logic finalTransfer;
        logic upper;
        logic lower;
        logic cwChanged;
        logic [31:0] rdData;
        logic irq;
        logic [3:0] pendEvt;
    } rmdem_top_t;
    rmdem_top_t state, next_state;
    logic grantValid, strobeError, timeoutError;
    logic [AW-1:0] grantIdx;
    logic active, wrapMode, oddMode, writeDir;
    logic strobeIn, upperIn, lowerIn, lastBeat, injectPoint;
    logic parityErr, timerErr, tdErr, cwErr, anyErr;
    logic syncStrobe1, syncStrobe2, syncUp1, syncUp2, syncLo1, syncLo2;
    logic syncPar1, syncPar2, syncTo1, syncTo2;
    logic [15:0] syncData1, syncData2;
    logic [2:0] errCode;
    logic advance;
    ////////////////////////////////////////////////////////////////////////
    // ring pins come from outside: two stages before use
    always_ff @(posedge sys_clk) begin
        syncStrobe1 <= ringStrobe;
        syncStrobe2 <= syncStrobe1;
        syncUp1 <= ringUpper;
        syncUp2 <= syncUp1;
        syncLo1 <= ringLower;
        syncLo2 <= syncLo1;
        syncPar1 <= ringParityErr;
        syncPar2 <= syncPar1;
        syncTo1 <= ringTimeout;
        syncTo2 <= syncTo1;
        // data takes the same two stages so it lines up with the strobe
        syncData1 <= ringData;
        syncData2 <= syncData1;
    end
    assign active = state.phase == rmdem_pkg::RMDEM_XFER;
    assign wrapMode = state.diag[rmdem_pkg::DIAG_WRAP];
    assign oddMode = state.diag[rmdem_pkg::DIAG_ODD_MODE];
    assign writeDir = state.diag[rmdem_pkg::DIAG_WRITE_DIR];
    assign lastBeat = state.beat == state.diag[COUNT_WIDTH-1:0];
    // injection point chosen by the count field
    assign injectPoint = active && lastBeat;
    // wrap mode: strobes generated locally from mode and count
    assign strobeIn = wrapMode ? active : syncStrobe2;
    assign upperIn = wrapMode ? !(oddMode && state.beat == '0) : syncUp2;
    assign lowerIn = wrapMode ? !(lastBeat && state.diag[0] == oddMode)
        : syncLo2;
    assign parityErr = active && (syncPar2
        || (injectPoint && state.diag[rmdem_pkg::DIAG_FORCE_PAR]));
    assign timerErr = active && (timeoutError || syncTo2
        || (injectPoint && state.diag[rmdem_pkg::DIAG_FORCE_TIMER]));
    assign tdErr = injectPoint && state.diag[rmdem_pkg::DIAG_FORCE_TD];
    assign cwErr = active && state.beat == '0
        && state.diag[rmdem_pkg::DIAG_FORCE_CW];
    assign anyErr = parityErr || timerErr || strobeError || cwErr;
    assign errCode = cwErr || strobeError ? rmdem_pkg::ERR_INTERNAL
        : timerErr ? rmdem_pkg::ERR_TYPE1
        : rmdem_pkg::ERR_TYPE2;
    assign advance = state.phase == rmdem_pkg::RMDEM_IDLE
        && state.diag[rmdem_pkg::DIAG_START];
    rmdem_scan_wheel #(.N(NUM_ADAPTERS)) wheel (
        .sys_clk(sys_clk),
        .srst(srst),
        .requests(state.busReq),
        .advance(advance),
        .grantValid(grantValid),
        .grantIdx(grantIdx)
    );
    rmdem_strobe_check #(
        .TIMER_WIDTH(rmdem_pkg::TIMER_WIDTH),
        .LIMIT(rmdem_pkg::STROBE_TIMEOUT_CYC)
    ) strobeChk (
        .sys_clk(sys_clk),
        .srst(srst),
        .active(active),
        .oddMode(oddMode),
        .firstBeat(state.beat == '0),
        .strobeSeen(strobeIn),
        .upperStrobe(upperIn),
        .lowerStrobe(lowerIn),
        .strobeError(strobeError),
        .timeoutError(timeoutError)
    );
    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        next_state = state;
        next_state.centralWrite = 1'b0;
        next_state.finalTransfer = 1'b0;
        next_state.upper = 1'b0;
        next_state.lower = 1'b0;
        next_state.rdData = '0;
        next_state.pendEvt = '0;
        // events raised last cycle reach status after their logs
        next_state.status = state.status | state.pendEvt;
        if (regWrite) begin
            unique case (regAddr)
                rmdem_pkg::OFF_CONTROL: next_state.routing = regWrData[3:0];
                rmdem_pkg::OFF_DIAG: next_state.diag = regWrData[11:0];
                rmdem_pkg::OFF_IRQ_REQ: next_state.irqReq = regWrData[3:0];
                rmdem_pkg::OFF_BUS_REQ: next_state.busReq = regWrData[3:0];
                rmdem_pkg::OFF_LEVEL_ONE: next_state.levelOne = '0;
                rmdem_pkg::OFF_IRQ_STATUS:
                    next_state.status = (state.status & ~regWrData[3:0])
                        | state.pendEvt;
                rmdem_pkg::OFF_IRQ_MASK: next_state.mask = regWrData[3:0];
                default: ;
            endcase
        end
        if (regRead) begin
            unique case (regAddr)
                rmdem_pkg::OFF_CONTROL:
                    next_state.rdData = {28'h0, state.routing};
                rmdem_pkg::OFF_DIAG: next_state.rdData = {20'h0, state.diag};
                rmdem_pkg::OFF_IRQ_REQ:
                    next_state.rdData = {28'h0, state.irqReq};
                rmdem_pkg::OFF_BUS_REQ:
                    next_state.rdData = {28'h0, state.busReq};
                rmdem_pkg::OFF_LEVEL_ONE:
                    next_state.rdData = {24'h0, state.levelOne};
                rmdem_pkg::OFF_LEVEL_TWO:
                    next_state.rdData = {20'h0, state.levelTwo};
                rmdem_pkg::OFF_MAINT: next_state.rdData = {28'h0, state.maint};
                rmdem_pkg::OFF_COMPLETION: begin
                    // query reports kind, then empties the maintenance log
                    next_state.rdData = {26'h0, state.kind, state.maint};
                    next_state.maint = '0;
                    next_state.kind = '0;
                end
                rmdem_pkg::OFF_IRQ_STATUS:
                    next_state.rdData = {28'h0, state.status};
                rmdem_pkg::OFF_IRQ_MASK:
                    next_state.rdData = {28'h0, state.mask};
                rmdem_pkg::OFF_IDENT:
                    next_state.rdData = {29'h0, state.cwChanged, state.serving};
                default: next_state.rdData = '0;
            endcase
        end
        // direct interrupt: routing, request and start together
        if ((state.routing & state.irqReq) != '0
            && state.diag[rmdem_pkg::DIAG_START]) begin
            next_state.kind[1] = 1'b1;
            next_state.pendEvt[rmdem_pkg::IRQ_DIRECT] = 1'b1;
        end
        unique case (state.phase)
            rmdem_pkg::RMDEM_IDLE: begin
                if (advance && grantValid) begin
                    // rotation picks the adapter; identifier shows it
                    next_state.serving = grantIdx;
                    next_state.busReq[grantIdx] = 1'b0;
                    next_state.beat = '0;
                    next_state.cwChanged = 1'b0;
                    next_state.phase = rmdem_pkg::RMDEM_XFER;
                end
            end
            rmdem_pkg::RMDEM_XFER: begin
                if (tdErr) begin
                    // adapter number kept with the level-one log
                    next_state.levelOne = {1'b1, 5'h0, state.serving};
                    next_state.pendEvt[rmdem_pkg::IRQ_LEVEL_ONE] = 1'b1;
                end
                if (anyErr) begin
                    // early end; no write, no buffer update
                    next_state.levelTwo[state.serving*3 +: 3] = errCode;
                    next_state.pendEvt[rmdem_pkg::IRQ_LEVEL_FOUR] = 1'b1;
                    if (cwErr) next_state.cwChanged = 1'b1;
                    if (state.routing[state.serving]) begin
                        next_state.maint = {1'b1, errCode};
                        next_state.kind[0] = 1'b1;
                        next_state.pendEvt[rmdem_pkg::IRQ_MAINT] = 1'b1;
                    end
                    next_state.phase = rmdem_pkg::RMDEM_DONE;
                end else if (strobeIn) begin
                    next_state.upper = upperIn;
                    next_state.lower = lowerIn;
                    next_state.finalTransfer = lastBeat;
                    if (writeDir) begin
                        // odd start swaps the two lanes
                        next_state.centralData = oddMode
                            ? {syncData2[7:0], syncData2[15:8]} : syncData2;
                        next_state.centralWrite = 1'b1;
                    end else begin
                        next_state.extBuf = state.dataBuf;
                        next_state.dataBuf = syncData2;
                    end
                    next_state.beat = state.beat + 1'b1;
                    if (lastBeat) next_state.phase = rmdem_pkg::RMDEM_DONE;
                end
            end
            rmdem_pkg::RMDEM_DONE: begin
                next_state.diag[rmdem_pkg::DIAG_START] = 1'b0;
                next_state.phase = rmdem_pkg::RMDEM_IDLE;
            end
            default: next_state.phase = rmdem_pkg::RMDEM_IDLE;
        endcase
        next_state.irq = (next_state.status & state.mask) != '0;
    end
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end
    assign regRdData = state.rdData;
    assign centralData = state.centralData;
    assign centralWrite = state.centralWrite;
    assign finalTransfer = state.finalTransfer;
    assign upperLowerUp = state.upper;
    assign upperLowerLo = state.lower;
    assign controlWordChanged = state.cwChanged;
    assign irq = state.irq;
    ////////////////////////////////////////////////////////////////////////
    a_error_ends_dma: assert property (@(posedge sys_clk) disable iff (srst)
        active && anyErr |=> state.phase == rmdem_pkg::RMDEM_DONE)
        else $error("error did not end transfer");
    a_error_no_write: assert property (@(posedge sys_clk) disable iff (srst)
        active && anyErr |=> !centralWrite)
        else $error("errored transfer wrote memory");
    a_timeout_keeps_buf: assert property (@(posedge sys_clk) disable iff (srst)
        active && timerErr |=> $stable(state.dataBuf) && $stable(state.extBuf))
        else $error("timeout changed buffers");
    a_level_one_log: assert property (@(posedge sys_clk) disable iff (srst)
        tdErr |=> state.levelOne[AW-1:0] == $past(state.serving)
        ##1 state.status[rmdem_pkg::IRQ_LEVEL_ONE])
        else $error("level one log or flag missing");
    a_status_before: assert property (@(posedge sys_clk) disable iff (srst)
        active && anyErr |=> !state.status[rmdem_pkg::IRQ_LEVEL_FOUR]
        || $past(state.status[rmdem_pkg::IRQ_LEVEL_FOUR]))
        else $error("interrupt flag rose with its log");
    a_direct_irq: assert property (@(posedge sys_clk) disable iff (srst)
        ((state.routing & state.irqReq) != '0)
        && state.diag[rmdem_pkg::DIAG_START]
        |-> ##2 state.status[rmdem_pkg::IRQ_DIRECT])
        else $error("direct interrupt not flagged");
    a_query_clears: assert property (@(posedge sys_clk) disable iff (srst)
        regRead && regAddr == rmdem_pkg::OFF_COMPLETION && !active
        |=> state.maint == '0)
        else $error("completion query left log");
    a_maint_log: assert property (@(posedge sys_clk) disable iff (srst)
        active && anyErr && state.routing[state.serving]
        |=> state.maint[3] ##1 state.status[rmdem_pkg::IRQ_MAINT])
        else $error("maintenance log missing");
endmodule
`default_nettype wire

// *** tb/rmdem_ring_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module rmdem_ring_model (
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic run,
    input wire logic badStrobe,
    output logic ringStrobe,
    output logic ringUpper,
    output logic ringLower,
    output logic ringParityErr,
    output logic ringTimeout,
    output logic [15:0] ringData
);
    // strobe toggles whenever run is high, between transfers too; it stays low otherwise
    always_ff @(posedge sys_clk) begin
        if (srst || !run) begin
            ringStrobe <= 1'b0;
        end else begin
            ringStrobe <= ~ringStrobe;
        end
    end
    // even-mode beats carry both halves; badStrobe drops the upper one
    assign ringUpper = run & ~badStrobe;
    assign ringLower = run;
    assign ringParityErr = 1'b0;
    assign ringTimeout = 1'b0;
    // released data shows the inverse, so a stale sample is visible
    assign ringData = run ? 16'h1234 : 16'hedcb;
endmodule
`default_nettype wire

// *** tb/test_ring_mux_dma_error_manager.sv ***
`timescale 1ns/1ps
`default_nettype none
module test_ring_mux_dma_error_manager;
    logic sys_clk = 1'b0;
    logic srst = 1'b1;
    logic [3:0] regAddr = 4'h0;
    logic [31:0] regWrData = 32'h0;
    logic regWrite = 1'b0;
    logic regRead = 1'b0;
    logic [31:0] regRdData;
    logic ringStrobe, ringUpper, ringLower, ringParityErr, ringTimeout;
    logic [15:0] ringData, centralData, lastData;
    logic [2:0] lastStb;
    logic centralWrite, finalTransfer, upperLowerUp, upperLowerLo;
    logic controlWordChanged, irq;
    logic run = 1'b0;
    logic bad = 1'b0;
    logic [31:0] v;
    logic [3:0] rl [8] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h9, 4'h7};
    logic [3:0] order [3] = '{4'h1, 4'h3, 4'h0};
    int failures = 0;
    int n_checks = 0;
    int nWr = 0;
    int wr0 = 0;
    int k;
    ////////////////////////////////////////////////////////////////////////
    always #2.5 sys_clk = ~sys_clk;
    always @(posedge sys_clk) begin
        if (centralWrite === 1'b1) begin
            nWr <= nWr + 1;
            lastData <= centralData;
            lastStb <= {finalTransfer, upperLowerUp, upperLowerLo};
        end
    end
    ring_mux_dma_error_manager dut (.sys_clk(sys_clk), .srst(srst),
        .regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite),
        .regRead(regRead), .regRdData(regRdData), .ringStrobe(ringStrobe),
        .ringUpper(ringUpper), .ringLower(ringLower),
        .ringParityErr(ringParityErr), .ringTimeout(ringTimeout),
        .ringData(ringData), .centralData(centralData),
        .centralWrite(centralWrite), .finalTransfer(finalTransfer),
        .upperLowerUp(upperLowerUp), .upperLowerLo(upperLowerLo),
        .controlWordChanged(controlWordChanged), .irq(irq));
    rmdem_ring_model ring (.sys_clk(sys_clk), .srst(srst), .run(run),
        .badStrobe(bad), .ringStrobe(ringStrobe), .ringUpper(ringUpper),
        .ringLower(ringLower), .ringParityErr(ringParityErr),
        .ringTimeout(ringTimeout), .ringData(ringData));
    ////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] b(input int n);
        return 32'h1 << n;
    endfunction
    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic test_done;
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // extra edge after each strobe so no signal is assigned twice at once
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        regAddr <= a;
        regWrData <= d;
        regWrite <= 1'b1;
        @(posedge sys_clk);
        regWrite <= 1'b0;
        @(posedge sys_clk);
    endtask
    task automatic rd(input logic [3:0] a, output logic [31:0] d);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge sys_clk);
        regRead <= 1'b0;
        #1 d = regRdData;
        @(posedge sys_clk);
    endtask
    // start clears when the transfer ends, so poll it under a bound
    task automatic dma(input logic [31:0] br, input logic [31:0] dg);
        int i;
        logic [31:0] s;
        wr0 = nWr;
        if (br !== 32'h0) wr(rmdem_pkg::OFF_BUS_REQ, br);
        wr(rmdem_pkg::OFF_DIAG, dg | b(rmdem_pkg::DIAG_START));
        for (i = 0; i < 100; i++) begin
            rd(rmdem_pkg::OFF_DIAG, s);
            if (s[rmdem_pkg::DIAG_START] === 1'b0) break;
        end
        if (i == 100) begin
            failures++;
            test_done();
        end
    endtask
    task automatic clr;
        wr(rmdem_pkg::OFF_IRQ_STATUS, 32'hf);
    endtask
    ////////////////////////////////////////////////////////////////////////
    localparam logic [31:0] WD = 32'h1 << rmdem_pkg::DIAG_WRITE_DIR;
    localparam logic [31:0] WR = WD | (32'h1 << rmdem_pkg::DIAG_WRAP);
    initial begin
        repeat (5) @(posedge sys_clk);
        srst <= 1'b0;
        @(posedge sys_clk);
        for (k = 0; k < 8; k++) begin
            rd(rl[k], v);
            chk("reset value", 32'h0, v);
        end
        $display("test reset done");
        dma(32'h1, WR | 32'h3);
        chk("wrap beats", 32'd4, nWr - wr0);
        chk("wrap strobes", 32'h7, {29'h0, lastStb});
        rd(rmdem_pkg::OFF_BUS_REQ, v);
        chk("served request", 32'h0, v);
        $display("test wrap done");
        wr(rmdem_pkg::OFF_IRQ_MASK, 32'hf);
        dma(32'h2, WR | b(rmdem_pkg::DIAG_FORCE_PAR) | 32'h2);
        chk("beats before error", 32'd2, nWr - wr0);
        chk("irq", 32'h1, {31'h0, irq});
        rd(rmdem_pkg::OFF_IRQ_STATUS, v);
        chk("level four", 32'h1, {31'h0, v[1]});
        rd(rmdem_pkg::OFF_LEVEL_TWO, v);
        chk("level two", {29'h0, rmdem_pkg::ERR_TYPE2}, v >> 3);
        clr();
        chk("irq cleared", 32'h0, {31'h0, irq});
        dma(32'h4, WR | b(rmdem_pkg::DIAG_FORCE_TIMER) | 32'h1);
        chk("beats before timer", 32'd1, nWr - wr0);
        rd(rmdem_pkg::OFF_LEVEL_TWO, v);
        chk("level two", {29'h0, rmdem_pkg::ERR_TYPE1}, v >> 6);
        clr();
        $display("test forced errors done");
        dma(32'h8, WR | b(rmdem_pkg::DIAG_FORCE_TD));
        rd(rmdem_pkg::OFF_IRQ_STATUS, v);
        chk("level one irq", 32'h1, {31'h0, v[0]});
        rd(rmdem_pkg::OFF_LEVEL_ONE, v);
        chk("level one", 32'h83, v);
        clr();
        $display("test level one done");
        wr(rmdem_pkg::OFF_CONTROL, 32'h1);
        dma(32'h1, WR | b(rmdem_pkg::DIAG_FORCE_PAR));
        rd(rmdem_pkg::OFF_MAINT, v);
        chk("maint", {28'h0, 1'b1, rmdem_pkg::ERR_TYPE2}, v);
        rd(rmdem_pkg::OFF_COMPLETION, v);
        chk("completion", {26'h0, 3'b011, rmdem_pkg::ERR_TYPE2}, v);
        rd(rmdem_pkg::OFF_MAINT, v);
        chk("maint cleared", 32'h0, v);
        clr();
        wr(rmdem_pkg::OFF_CONTROL, 32'h8);
        wr(rmdem_pkg::OFF_IRQ_REQ, 32'h8);
        wr(rmdem_pkg::OFF_DIAG, b(rmdem_pkg::DIAG_START));
        // flag lands two edges after start, one more than the write gives
        @(posedge sys_clk);
        rd(rmdem_pkg::OFF_IRQ_STATUS, v);
        chk("direct", 32'h1, {31'h0, v[3]});
        rd(rmdem_pkg::OFF_COMPLETION, v);
        chk("kind", 32'h2, {30'h0, v[5:4]});
        wr(rmdem_pkg::OFF_DIAG, 32'h0);
        wr(rmdem_pkg::OFF_IRQ_REQ, 32'h0);
        wr(rmdem_pkg::OFF_CONTROL, 32'h0);
        clr();
        $display("test maintenance done");
        // adapter 0 went last, so the wheel resumes at 1
        wr(rmdem_pkg::OFF_BUS_REQ, 32'hb);
        for (k = 0; k < 3; k++) begin
            dma(32'h0, WR | b(rmdem_pkg::DIAG_FORCE_CW));
            rd(rmdem_pkg::OFF_IDENT, v);
            chk("identifier", {28'h0, order[k]} | 32'h4, v);
            chk("cw changed", 32'h1, {31'h0, controlWordChanged});
            clr();
        end
        $display("test scan wheel done");
        run <= 1'b1;
        dma(32'h1, WD);
        chk("even data", 32'h1234, {16'h0, lastData});
        dma(32'h1, WR | b(rmdem_pkg::DIAG_ODD_MODE));
        chk("odd data", 32'h3412, {16'h0, lastData});
        chk("odd strobes", 32'h5, {29'h0, lastStb});
        run <= 1'b0;
        // read direction, so the timeout must leave the buffers alone
        dma(32'h1, 32'h0);
        rd(rmdem_pkg::OFF_IRQ_STATUS, v);
        chk("strobe timeout", 32'h1, {31'h0, v[1]});
        clr();
        run <= 1'b1;
        bad <= 1'b1;
        dma(32'h1, WD);
        rd(rmdem_pkg::OFF_IRQ_STATUS, v);
        chk("strobe mismatch", 32'h1, {31'h0, v[1]});
        run <= 1'b0;
        bad <= 1'b0;
        $display("test ring side done");
        test_done();
    end
    initial begin
        #300000;
        failures++;
        test_done();
    end
endmodule
`default_nettype wire
